// ===== ibr_core.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module ibr_core (
  input wire logic mclk, // 25 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [ibr_pkg::AW-1:0] reg_addr, // register index
  input wire logic [ibr_pkg::DW-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [ibr_pkg::DW-1:0] reg_rdata, // read data, next cycle
  input wire logic scl_i, // bus clock level
  input wire logic sda_i, // bus data level
  output logic sda_o, // data out, always low
  output logic sda_oe, // pulls data low while high
  output logic irq // level interrupt
);
  import ibr_pkg::*;

  // ==========================================================
  // pin synchronisers and condition detect
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_i, sda_s1_r, sda_s2_r};
    end
  end
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire scl_high = scl_s2_r & scl_d_r;
  wire start_det = scl_high & sda_d_r & ~sda_s2_r;
  wire stop_det = scl_high & ~sda_d_r & sda_s2_r;

  // ==========================================================
  // registers
  logic [7:0] rx_byte_field_r, tx_byte_field_r, rx_sh_r, tx_sh_r;
  logic tx_full_r, ifg_rx_r, general_call_respond_en_r;
  logic [ADDR_W-1:0] own_address_field_r, target_address_field_r;
  logic [3:0] evt_ie_r, evt_stat_r, ctl_r, cnt_r;
  logic ch0_tx_irq_en_r, ch0_rx_irq_en_r;
  logic drv_r, addressed_r, sda_oe_r, irq_r;
  logic [DW-1:0] rdata_r;
  ibr_phase_e phase_r, phase_nxt;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] off);
    hit = (a == off);
  endfunction

  wire wr_tx = reg_wr & hit(reg_addr, OFF_TX_BUF);
  wire wr_own = reg_wr & hit(reg_addr, OFF_OWN_ADDR);
  wire wr_tgt = reg_wr & hit(reg_addr, OFF_TGT_ADDR);
  wire wr_ie = reg_wr & hit(reg_addr, OFF_EVT_IE);
  wire wr_ch0_ie = reg_wr & hit(reg_addr, OFF_CH0_IE);
  wire wr_ch0_flag = reg_wr & hit(reg_addr, OFF_CH0_FLAG);
  wire wr_stat = reg_wr & hit(reg_addr, OFF_EVT_STAT);
  wire wr_ctl = reg_wr & hit(reg_addr, OFF_CTL);
  wire rd_rx = reg_rd & hit(reg_addr, OFF_RX_BUF);

  // ==========================================================
  // shift engine decode
  wire is_master = ctl_r[CTL_MASTER];
  wire ten_mode = ctl_r[CTL_TEN];
  wire rd_mode = ctl_r[CTL_READ];
  wire busy = (phase_r != PH_IDLE);
  wire bit_in = sda_s2_r;
  wire [7:0] rx_next = {rx_sh_r[6:0], bit_in};
  // address byte: 7-bit form drops bits 9..7, 10-bit form sends the
  // prefix with bits 9..8 first, then bits 7..0 as a second byte
  wire [7:0] addr_byte1 = ten_mode ?
    {TEN_PREFIX, target_address_field_r[9:8], rd_mode} :
    {target_address_field_r[6:0], rd_mode};
  wire byte_done = scl_rise & busy & (cnt_r == LAST_BIT);
  wire ack_rise = scl_rise & busy & (cnt_r == ACK_BIT);
  wire arb_lost = scl_rise & busy & drv_r & is_master &
                  (cnt_r < ACK_BIT) & ~sda_oe_r & ~bit_in;
  wire own_hit = (rx_next[7:1] == own_address_field_r[6:0]);
  wire gc_hit = general_call_respond_en_r & (rx_next == BYTE_ZERO);
  wire rx_store = byte_done & (phase_r == PH_DATA) & ~drv_r &
                  (is_master | addressed_r);
  wire nack_det = ack_rise & is_master & drv_r & bit_in;
  wire need_second = is_master & ten_mode & (phase_r == PH_ADR1);
  // next byte comes from the buffer only when writing as master
  wire tx_load = ack_rise & is_master & drv_r & ~bit_in & ~need_second &
                 ~rd_mode & tx_full_r;
  wire ack_mine = ~drv_r & (is_master ? (phase_r == PH_DATA) : addressed_r);
  wire start_gen = ctl_r[CTL_START] & is_master & ~busy & scl_high;
  wire [3:0] evt_set = {nack_det, stop_det, start_det, arb_lost};

  always_comb begin
    phase_nxt = phase_r;
    if (stop_det | arb_lost) begin
      phase_nxt = PH_IDLE;
    end else if (start_det) begin
      phase_nxt = PH_ADR1;
    end else if (ack_rise) begin
      case (phase_r)
        PH_ADR1: phase_nxt = need_second ? PH_ADR2 : PH_DATA;
        PH_ADR2: phase_nxt = PH_DATA;
        default: phase_nxt = phase_r;
      endcase
    end
  end

  // ==========================================================
  // engine state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_r <= PH_IDLE;
      cnt_r <= EV_RST;
    end else begin
      phase_r <= phase_nxt;
      if (start_det) begin
        cnt_r <= EV_RST;
      end else if (scl_rise & busy) begin
        cnt_r <= (cnt_r == ACK_BIT) ? EV_RST : cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_sh_r <= BYTE_ZERO;
      addressed_r <= 1'b0;
    end else begin
      if (scl_rise & busy & (cnt_r < ACK_BIT)) begin
        rx_sh_r <= rx_next;
      end
      if (start_det) begin
        addressed_r <= 1'b0;
      end else if (byte_done & (phase_r == PH_ADR1) & ~is_master) begin
        addressed_r <= own_hit | gc_hit;
      end
    end
  end

  // target address only reaches the line while acting as master
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_sh_r <= BYTE_ZERO;
      drv_r <= 1'b0;
    end else if (stop_det | arb_lost) begin
      drv_r <= 1'b0;
    end else if (start_det) begin
      drv_r <= is_master;
      tx_sh_r <= is_master ? addr_byte1 : BYTE_ZERO;
    end else if (ack_rise & is_master & drv_r) begin
      if (bit_in) begin
        drv_r <= 1'b0;
      end else if (need_second) begin
        tx_sh_r <= target_address_field_r[7:0];
      end else if (tx_load) begin
        tx_sh_r <= tx_byte_field_r;
      end else begin
        drv_r <= 1'b0;
      end
    end else if (scl_fall & busy & (cnt_r < ACK_BIT)) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  // open drain: a one is sent by releasing the line
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sda_oe_r <= 1'b0;
    end else if (stop_det | arb_lost) begin
      sda_oe_r <= 1'b0;
    end else if (start_gen) begin
      sda_oe_r <= 1'b1;
    end else if (scl_fall & busy) begin
      sda_oe_r <= (cnt_r == ACK_BIT) ? ack_mine : drv_r & ~tx_sh_r[7];
    end
  end

  // ==========================================================
  // buffers, flags and control
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_byte_field_r <= BYTE_ZERO;
      tx_byte_field_r <= BYTE_ZERO;
      tx_full_r <= 1'b0;
      ifg_rx_r <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_byte_field_r <= rx_next;
      end
      if (wr_tx) begin
        tx_byte_field_r <= reg_wdata[7:0];
      end
      // a write beside a load keeps the new byte, so the buffer stays full
      tx_full_r <= wr_tx | (tx_full_r & ~tx_load);
      ifg_rx_r <= rx_store |
        (ifg_rx_r & ~rd_rx & ~(wr_ch0_flag & reg_wdata[CH0_RX_BIT]));
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      general_call_respond_en_r <= 1'b0;
      own_address_field_r <= ADDR_RST;
      target_address_field_r <= ADDR_RST;
      evt_ie_r <= EV_RST;
      ch0_tx_irq_en_r <= 1'b0;
      ch0_rx_irq_en_r <= 1'b0;
    end else begin
      if (wr_own) begin
        general_call_respond_en_r <= reg_wdata[OA_GCEN_BIT];
        own_address_field_r <= reg_wdata[ADDR_W-1:0];
      end
      if (wr_tgt) begin
        target_address_field_r <= reg_wdata[ADDR_W-1:0];
      end
      if (wr_ie) begin
        evt_ie_r <= reg_wdata[3:0];
      end
      if (wr_ch0_ie) begin
        ch0_tx_irq_en_r <= reg_wdata[CH0_TX_BIT];
        ch0_rx_irq_en_r <= reg_wdata[CH0_RX_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_stat_r <= EV_RST;
      ctl_r <= EV_RST;
    end else begin
      evt_stat_r <= evt_set |
        (evt_stat_r & ~({4{wr_stat}} & reg_wdata[3:0]));
      if (wr_ctl) begin
        ctl_r <= reg_wdata[3:0];
      end else if (start_det) begin
        ctl_r[CTL_START] <= 1'b0;
      end
    end
  end

  wire pending = |(evt_stat_r & evt_ie_r) |
                 (~tx_full_r & ch0_tx_irq_en_r) |
                 (ifg_rx_r & ch0_rx_irq_en_r);

  // ==========================================================
  // read port and outputs
  logic [DW-1:0] rd_mux;
  always_comb begin
    if (hit(reg_addr, OFF_RX_BUF)) begin
      rd_mux = {8'h00, rx_byte_field_r};
    end else if (hit(reg_addr, OFF_TX_BUF)) begin
      rd_mux = {8'h00, tx_byte_field_r};
    end else if (hit(reg_addr, OFF_OWN_ADDR)) begin
      rd_mux = {general_call_respond_en_r, 5'h00, own_address_field_r};
    end else if (hit(reg_addr, OFF_TGT_ADDR)) begin
      rd_mux = {6'h00, target_address_field_r};
    end else if (hit(reg_addr, OFF_EVT_IE)) begin
      rd_mux = {12'h000, evt_ie_r};
    end else if (hit(reg_addr, OFF_CH0_IE)) begin
      rd_mux = {12'h000, ch0_tx_irq_en_r, ch0_rx_irq_en_r, 2'h0};
    end else if (hit(reg_addr, OFF_CH0_FLAG)) begin
      rd_mux = {12'h000, ~tx_full_r, ifg_rx_r, 2'h0};
    end else if (hit(reg_addr, OFF_EVT_STAT)) begin
      rd_mux = {12'h000, evt_stat_r};
    end else if (hit(reg_addr, OFF_CTL)) begin
      rd_mux = {12'h000, ctl_r};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
      irq_r <= pending;
    end
  end

  assign reg_rdata = rdata_r;
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  chk_rx_buffer_load: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_store |=> rx_byte_field_r == $past(rx_next))
    else $error("receive buffer did not take the finished byte");
  chk_tx_buffer_write: assert property (@(posedge mclk)
    disable iff (sys_rst)
    wr_tx |=> tx_byte_field_r == $past(reg_wdata[7:0]))
    else $error("transmit buffer did not take the written byte");
  chk_tx_flag_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_tx ##1 reg_rd && hit(reg_addr, OFF_CH0_FLAG)
    |=> !reg_rdata[CH0_TX_BIT])
    else $error("transmit empty flag still set after a buffer write");
  chk_slave_no_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    start_det && !is_master |=> !drv_r && tx_sh_r == 8'h00)
    else $error("target address used outside master operation");
  chk_addr_seven: assert property (@(posedge mclk) disable iff (sys_rst)
    start_det && is_master && !ten_mode |=>
    tx_sh_r[7:1] == $past(target_address_field_r[6:0]))
    else $error("7-bit address byte wrong");
  chk_addr_ten: assert property (@(posedge mclk) disable iff (sys_rst)
    start_det && is_master && ten_mode |=>
    tx_sh_r[2:1] == $past(target_address_field_r[9:8]))
    else $error("10-bit address byte wrong");
  chk_tx_empty_set: assert property (@(posedge mclk) disable iff (sys_rst)
    tx_load && !wr_tx |=> !tx_full_r ##1 (irq || !ch0_tx_irq_en_r))
    else $error("transmit empty flag not set after load");
  chk_ie_layout: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_ie ##1 reg_rd && hit(reg_addr, OFF_EVT_IE)
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
    else $error("event enable register read back wrong");
  chk_irq_gating: assert property (@(posedge mclk) disable iff (sys_rst)
    (evt_stat_r & evt_ie_r) == 4'h0 && !(~tx_full_r & ch0_tx_irq_en_r) &&
    !(ifg_rx_r & ch0_rx_irq_en_r) |=> !irq)
    else $error("interrupt raised with no enabled flag");
  chk_ch0_tx_irq: assert property (@(posedge mclk) disable iff (sys_rst)
    !tx_full_r && ch0_tx_irq_en_r |=> irq)
    else $error("enabled transmit flag gave no interrupt");
endmodule // ibr_core

// ===== ibr_i2c_peer.sv
`timescale 1ns/100ps
// ==========================================================
// far bus party: makes the bus clock, drives data open drain
module ibr_i2c_peer (
  input wire logic mclk, // sampling clock
  input wire logic sda, // resolved data line
  output logic scl, // bus clock, idle high
  output logic pull // pulls data low while high
);
  // clock stands still high outside frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic start_cond();
    pull <= 1'b1;
    wt(4);
  endtask
  task automatic stop_cond();
    scl <= 1'b0;
    wt(3);
    pull <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    pull <= 1'b0;
    wt(4);
  endtask
  // bounded: gives up when the far master never pulls data low
  task automatic wait_start(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge mclk);
      ok = (sda === 1'b0);
    end
    wt(4);
  endtask
  // eight bits msb first then the ack bit; data changes only with scl low
  task automatic xfer(input logic [7:0] drv, input logic ack_drv,
                      output logic [7:0] got, output logic ack_got);
    logic [8:0] word;
    logic [8:0] seen;
    word = {drv, ack_drv};
    seen = 9'h000;
    for (int i = 8; i >= 0; i--) begin
      scl <= 1'b0;
      wt(3);
      pull <= ~word[i];
      wt(3);
      scl <= 1'b1;
      wt(1);
      seen[i] = sda;
      wt(1);
    end
    got = seen[8:1];
    ack_got = seen[0];
  endtask
endmodule // ibr_i2c_peer

// ===== ibr_pkg.sv
// Functional notes
// - A read-only 8-bit receive buffer returns the last byte moved in from the receive shift register.
// - A writable 8-bit transmit buffer holds a byte until it is loaded into the transmit shift register.
// - Writing the transmit buffer clears the transmit-buffer-empty flag.
// - The 10-bit target address is used only while the block acts as bus master.
// - The target address is right-justified, its lowest bit at position zero.
// - In 7-bit addressing, bit 6 of the target address is the top bit and bits 9 to 7 are ignored.
// - In 10-bit addressing the whole target field is used, bit 9 being the top bit.
// - The shared enable register holds the channel-0 transmit enable at bit 3 and receive enable at bit 2.
// - The channel-0 transmit flag is set whenever the transmit buffer is empty.
package ibr_pkg;
  // ==========================================================
  // register port
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFF_RX_BUF = 4'h0;
  localparam logic [AW-1:0] OFF_TX_BUF = 4'h1;
  localparam logic [AW-1:0] OFF_OWN_ADDR = 4'h2;
  localparam logic [AW-1:0] OFF_TGT_ADDR = 4'h3;
  localparam logic [AW-1:0] OFF_EVT_IE = 4'h4;
  localparam logic [AW-1:0] OFF_CH0_IE = 4'h5;
  localparam logic [AW-1:0] OFF_CH0_FLAG = 4'h6;
  localparam logic [AW-1:0] OFF_EVT_STAT = 4'h7;
  localparam logic [AW-1:0] OFF_CTL = 4'h8;
  // ==========================================================
  // field layout
  localparam int ADDR_W = 10;
  localparam int OA_GCEN_BIT = 15;
  localparam int CH0_TX_BIT = 3;
  localparam int CH0_RX_BIT = 2;
  localparam int EV_NACK = 3;
  localparam int EV_STOP = 2;
  localparam int EV_START = 1;
  localparam int EV_ARB = 0;
  localparam int CTL_MASTER = 0;
  localparam int CTL_TEN = 1;
  localparam int CTL_READ = 2;
  localparam int CTL_START = 3;
  // ==========================================================
  // constants and reset values
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] EV_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADR1 = 2'b01,
    PH_ADR2 = 2'b11,
    PH_DATA = 2'b10
  } ibr_phase_e;
endpackage

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  import ibr_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_rd, sda_o, sda_oe, irq, scl, peer_pull;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic [7:0] got;
  logic ackg;
  wire sda_line;
  int fails, cmp_count;
  // pull-up on data: low whenever either party pulls
  assign sda_line = ~((sda_oe & ~sda_o) | peer_pull);
  ibr_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq));
  ibr_i2c_peer u_peer (.mclk(mclk), .sda(sda_line), .scl(scl),
    .pull(peer_pull));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp,
                        input logic [DW-1:0] mask);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & mask, exp);
  endtask
  // irq lags its cause by a cycle, so let it land before looking
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge mclk);
    #1 chk({15'h0, irq}, {15'h0, exp});
  endtask
  task automatic wait_go();
    bit ok;
    u_peer.wait_start(ok);
    if (!ok) begin
      fails++;
      final_report();
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk(OFF_OWN_ADDR, 16'h0000, 16'hFFFF);
    rd_chk(OFF_TGT_ADDR, 16'h0000, 16'hFFFF);
    rd_chk(OFF_EVT_IE, 16'h0000, 16'hFFFF);
    rd_chk(OFF_CH0_IE, 16'h0000, 16'hFFFF);
    rd_chk(OFF_CH0_FLAG, 16'h0008, 16'h0008);
  endtask
  task automatic t_fields();
    wr(OFF_OWN_ADDR, 16'hFFFF);
    rd_chk(OFF_OWN_ADDR, 16'h83FF, 16'hFFFF);
    wr(OFF_TGT_ADDR, 16'hFFFF);
    rd_chk(OFF_TGT_ADDR, 16'h03FF, 16'hFFFF);
    wr(OFF_EVT_IE, 16'hFFFF);
    rd_chk(OFF_EVT_IE, 16'h000F, 16'hFFFF);
    wr(OFF_CH0_IE, 16'hFFFF);
    rd_chk(OFF_CH0_IE, 16'h000C, 16'hFFFF);
    rd_chk(4'hF, 16'h0000, 16'hFFFF);
    wr(OFF_EVT_IE, 16'h0000);
    wr(OFF_CH0_IE, 16'h0000);
    wr(OFF_OWN_ADDR, 16'h0000);
  endtask
  task automatic t_tx_irq();
    wr(OFF_CH0_IE, 16'h0008);
    irq_chk(1'b1);
    wr(OFF_TX_BUF, 16'h00AB);
    rd_chk(OFF_TX_BUF, 16'h00AB, 16'h00FF);
    rd_chk(OFF_CH0_FLAG, 16'h0000, 16'h0008);
    irq_chk(1'b0);
    wr(OFF_CH0_IE, 16'h0000);
  endtask
  // bits 9..7 set on purpose: 7-bit mode must drop them
  task automatic t_master7();
    wr(OFF_TGT_ADDR, 16'h03A5);
    wr(OFF_CTL, 16'h0009);
    wait_go();
    u_peer.xfer(8'hFF, 1'b0, got, ackg);
    chk({8'h00, got}, 16'h004A);
    u_peer.xfer(8'hFF, 1'b0, got, ackg);
    chk({8'h00, got}, 16'h00AB);
    u_peer.stop_cond();
    rd_chk(OFF_CH0_FLAG, 16'h0008, 16'h0008);
    rd_chk(OFF_EVT_STAT, 16'h0004, 16'h0004);
    wr(OFF_EVT_IE, 16'h0004);
    irq_chk(1'b1);
    wr(OFF_EVT_STAT, 16'h000F);
    irq_chk(1'b0);
    wr(OFF_EVT_IE, 16'h0000);
  endtask
  // far side refuses the second address byte
  task automatic t_master10();
    wr(OFF_TGT_ADDR, 16'h02C5);
    wr(OFF_TX_BUF, 16'h0011);
    wr(OFF_CTL, 16'h000B);
    wait_go();
    u_peer.xfer(8'hFF, 1'b0, got, ackg);
    chk({8'h00, got}, 16'h00F4);
    u_peer.xfer(8'hFF, 1'b1, got, ackg);
    chk({8'h00, got}, 16'h00C5);
    u_peer.stop_cond();
    rd_chk(OFF_EVT_STAT, 16'h0008, 16'h0008);
    wr(OFF_EVT_IE, 16'h0008);
    irq_chk(1'b1);
    wr(OFF_EVT_STAT, 16'h000F);
    wr(OFF_EVT_IE, 16'h0000);
    wr(OFF_CTL, 16'h0000);
  endtask
  task automatic t_slave_rx();
    wr(OFF_OWN_ADDR, 16'h0052);
    u_peer.start_cond();
    u_peer.xfer(8'hA4, 1'b1, got, ackg);
    chk({15'h0, ackg}, 16'h0000);
    u_peer.xfer(8'h3C, 1'b1, got, ackg);
    u_peer.stop_cond();
    rd_chk(OFF_CH0_FLAG, 16'h0004, 16'h0004);
    rd_chk(OFF_RX_BUF, 16'h003C, 16'h00FF);
    rd_chk(OFF_CH0_FLAG, 16'h0000, 16'h0004);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_tx_irq();
    t_master7();
    t_master10();
    t_slave_rx();
    final_report();
  end
endmodule // tb
